// file: comparator_pkg.sv
package comparator_pkg;
    localparam logic [7:0] ctrl_addr = 8'h9b;
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] mux_addr = 8'h9f;
    localparam logic [7:0] mux_reset = 8'hff;
    localparam logic [7:0] mode_addr = 8'h9d;
    localparam logic [7:0] mode_reset = 8'h02;
    localparam logic [7:0] mask_addr = 8'h9c;
    localparam logic [7:0] mask_reset = 8'h00;
    localparam int enable_bit = 7;
    localparam int state_bit = 6;
    localparam int rise_bit = 5;
    localparam int fall_bit = 4;
    localparam int pos_hyst_lsb = 2;
    localparam int neg_hyst_lsb = 0;
    localparam int rise_mask_bit = 1;
    localparam int fall_mask_bit = 0;
    localparam int mode_lsb = 0;
    localparam int mode_width = 2;
    localparam int pos_sel_lsb = 0;
    localparam int neg_sel_lsb = 4;
    localparam int sel_width = 4;
    localparam logic [1:0] hyst_off = 2'h0;
    localparam logic [1:0] hyst_5mv = 2'h1;
    localparam logic [1:0] hyst_10mv = 2'h2;
    localparam logic [1:0] hyst_20mv = 2'h3;
endpackage : comparator_pkg

// file: voltage_comparator_control.sv
// Summary of operation
// - Control bit 7 written 1 enables the comparator, written 0 disables it.
// - Control bit 6 reads the present comparator output, read only.
// - A falling output edge sets the fall flag, control bit 4.
// - A rising output edge sets the rise flag, control bit 5.
// - Edge flags stay set until software writes them 0.
// - Rising and falling edges each raise their own interrupt request.
// - Rise request is forwarded only while its mask bit is 1.
// - Fall request is forwarded only while its mask bit is 1.
// - Bits 1-0 select negative hysteresis; code 11 gives 20 mV.
// - Bits 3-2 select positive hysteresis the same way.
// - Two outputs: one registered to clk, one raw from the comparator.
// - Raw output follows the comparator even with the clock stopped.
// - While disabled, both routed outputs are driven low, the clocked one from the next clk edge.
// - Spurious edge flags may appear after enable or mode changes.
// - Control register at address 0x9B, resets to all zeros.
// - Input select register picks positive and negative input pins.
// - Response mode register selects speed versus supply current.
// - Comparator output is offered as an optional reset source.
`timescale 1ns/1ps
module voltage_comparator_control
    import comparator_pkg::*;
#(
    parameter int sfr_width = 8, // Register width, fixed by the bus ports
    parameter int sync_stages = 2, // Flip-flops on the raw comparator input
    parameter int hyst_width = 2 // Width of each hysteresis code
)
(
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [7:0] sfr_addr, // Register address
    input wire logic [7:0] sfr_wdata, // Write data
    input wire logic sfr_wr, // Write strobe
    input wire logic sfr_rd, // Read strobe
    output logic [7:0] sfr_rdata, // Read data, registered
    input wire logic cmp_raw, // Analog comparator result
    input wire logic reset_src_en, // Comparator reset source enable
    output logic cmp_enable, // Analog enable
    output logic [1:0] pos_hyst_sel, // Positive hysteresis code
    output logic [1:0] neg_hyst_sel, // Negative hysteresis code
    output logic [3:0] pos_input_sel, // Positive input pin select
    output logic [3:0] neg_input_sel, // Negative input pin select
    output logic [1:0] response_mode, // Response time select
    output logic cmp_sync_out, // Clock-latched output
    output logic cmp_async_out, // Raw output, clockless
    output logic rise_irq, // Masked rise request
    output logic fall_irq, // Masked fall request
    output logic cmp_reset_req // Reset request to device
);
    // Elaboration checks on the parameters
    if (sfr_width != 8) begin : g_bad_sfr_width
        $error("sfr_width must be 8");
    end
    if (sync_stages < 2) begin : g_bad_sync_stages
        $error("sync_stages must be at least 2");
    end
    if (hyst_width != 2) begin : g_bad_hyst_width
        $error("hyst_width must be 2");
    end

    // Address decode shared by the write and read paths
    function automatic logic addr_hit(
        input logic [7:0] addr,
        input logic [7:0] target
    );
        return addr == target;
    endfunction : addr_hit

    // Edge test on the synchronised comparator level
    function automatic logic edge_seen(
        input logic enabled,
        input logic now_level,
        input logic last_level,
        input logic rising
    );
        logic moved;
        moved = enabled && (now_level != last_level);
        return moved && (now_level == rising);
    endfunction : edge_seen

    // Sticky flag; a hardware set beats a software write in the same cycle
    function automatic logic sticky_next(
        input logic flag,
        input logic set_event,
        input logic write_hit,
        input logic write_value
    );
        logic result;
        result = flag;
        if (write_hit) begin
            result = write_value;
        end
        if (set_event) begin
            result = 1'b1;
        end
        return result;
    endfunction : sticky_next

    // Request level held while the flag stands and its mask is set
    function automatic logic masked_request(
        input logic flag,
        input logic set_event,
        input logic mask
    );
        return (flag || set_event) && mask;
    endfunction : masked_request

    function automatic logic [1:0] hyst_field(
        input logic [7:0] data,
        input int lsb
    );
        return data[lsb +: 2];
    endfunction : hyst_field

    function automatic logic [7:0] hold_or_load(
        input logic load,
        input logic [7:0] now_value,
        input logic [7:0] new_value
    );
        return load ? new_value : now_value;
    endfunction : hold_or_load

    logic [sync_stages-1:0] sync_chain;
    logic [7:0] input_select_reg;
    logic [7:0] response_mode_reg;
    logic [7:0] irq_mask_reg;
    logic rise_edge_flag;
    logic fall_edge_flag;
    logic cmp_state;
    logic cmp_prev;

    logic synced_level;
    logic wr_ctrl;
    logic wr_mux;
    logic wr_mode;
    logic wr_mask;
    logic rd_ctrl;
    logic rd_mux;
    logic rd_mode;
    logic rd_mask;
    logic rise_event;
    logic fall_event;
    logic rise_irq_mask;
    logic fall_irq_mask;
    logic [7:0] ctrl_view;

    logic next_cmp_state;
    logic next_cmp_enable;
    logic [1:0] next_pos_hyst_sel;
    logic [1:0] next_neg_hyst_sel;
    logic next_rise_edge_flag;
    logic next_fall_edge_flag;
    logic [7:0] next_input_select;
    logic [7:0] next_response_mode;
    logic [7:0] next_irq_mask;
    logic next_rise_irq;
    logic next_fall_irq;
    logic next_sync_out;
    logic next_reset_req;
    logic [7:0] next_rdata;

    assign synced_level = sync_chain[sync_stages-1];
    assign wr_ctrl = sfr_wr && addr_hit(sfr_addr, ctrl_addr);
    assign wr_mux = sfr_wr && addr_hit(sfr_addr, mux_addr);
    assign wr_mode = sfr_wr && addr_hit(sfr_addr, mode_addr);
    assign wr_mask = sfr_wr && addr_hit(sfr_addr, mask_addr);
    assign rd_ctrl = addr_hit(sfr_addr, ctrl_addr);
    assign rd_mux = addr_hit(sfr_addr, mux_addr);
    assign rd_mode = addr_hit(sfr_addr, mode_addr);
    assign rd_mask = addr_hit(sfr_addr, mask_addr);

    assign rise_event = edge_seen(cmp_enable, cmp_state, cmp_prev, 1'b1);
    assign fall_event = edge_seen(cmp_enable, cmp_state, cmp_prev, 1'b0);
    assign ctrl_view = {cmp_enable, cmp_state, rise_edge_flag, fall_edge_flag,
                        pos_hyst_sel, neg_hyst_sel};
    assign rise_irq_mask = irq_mask_reg[rise_mask_bit];
    assign fall_irq_mask = irq_mask_reg[fall_mask_bit];

    assign next_cmp_state = synced_level && cmp_enable;
    assign next_cmp_enable = wr_ctrl ? sfr_wdata[enable_bit] : cmp_enable;
    assign next_pos_hyst_sel = wr_ctrl ? hyst_field(sfr_wdata, pos_hyst_lsb) : pos_hyst_sel;
    assign next_neg_hyst_sel = wr_ctrl ? hyst_field(sfr_wdata, neg_hyst_lsb) : neg_hyst_sel;
    assign next_rise_edge_flag = sticky_next(rise_edge_flag, rise_event, wr_ctrl,
                                             sfr_wdata[rise_bit]);
    assign next_fall_edge_flag = sticky_next(fall_edge_flag, fall_event, wr_ctrl,
                                             sfr_wdata[fall_bit]);
    assign next_input_select = hold_or_load(wr_mux, input_select_reg, sfr_wdata);
    assign next_response_mode = hold_or_load(wr_mode, response_mode_reg, sfr_wdata);
    assign next_irq_mask = hold_or_load(wr_mask, irq_mask_reg, sfr_wdata);
    assign next_rise_irq = masked_request(rise_edge_flag, rise_event, rise_irq_mask);
    assign next_fall_irq = masked_request(fall_edge_flag, fall_event, fall_irq_mask);
    assign next_sync_out = cmp_state && cmp_enable;
    assign next_reset_req = reset_src_en && cmp_enable && !cmp_state;
    assign next_rdata = rd_ctrl ? ctrl_view :
                        rd_mux ? input_select_reg :
                        rd_mode ? response_mode_reg :
                        rd_mask ? irq_mask_reg :
                        8'h00;

    assign pos_input_sel = input_select_reg[pos_sel_lsb +: sel_width];
    assign neg_input_sel = input_select_reg[neg_sel_lsb +: sel_width];
    assign response_mode = response_mode_reg[mode_lsb +: mode_width];

    // Raw path is pure gating so it works without clk
    assign cmp_async_out = cmp_raw & cmp_enable;

    // Only the last stage is read by logic
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_chain <= '0;
        end else begin
            sync_chain <= {sync_chain[sync_stages-2:0], cmp_raw};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_state <= 1'b0;
        end else begin
            cmp_state <= next_cmp_state;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_prev <= 1'b0;
        end else begin
            cmp_prev <= cmp_state;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_enable <= ctrl_reset[enable_bit];
        end else begin
            cmp_enable <= next_cmp_enable;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pos_hyst_sel <= hyst_off;
        end else begin
            pos_hyst_sel <= next_pos_hyst_sel;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            neg_hyst_sel <= hyst_off;
        end else begin
            neg_hyst_sel <= next_neg_hyst_sel;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rise_edge_flag <= 1'b0;
        end else begin
            rise_edge_flag <= next_rise_edge_flag;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fall_edge_flag <= 1'b0;
        end else begin
            fall_edge_flag <= next_fall_edge_flag;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            input_select_reg <= mux_reset;
        end else begin
            input_select_reg <= next_input_select;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            response_mode_reg <= mode_reset;
        end else begin
            response_mode_reg <= next_response_mode;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_reg <= mask_reset;
        end else begin
            irq_mask_reg <= next_irq_mask;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rise_irq <= 1'b0;
        end else begin
            rise_irq <= next_rise_irq;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fall_irq <= 1'b0;
        end else begin
            fall_irq <= next_fall_irq;
        end
    end

    // Gated by enable too, so the pin drops one edge after a disable
    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_sync_out <= 1'b0;
        end else begin
            cmp_sync_out <= next_sync_out;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_reset_req <= 1'b0;
        end else begin
            cmp_reset_req <= next_reset_req;
        end
    end

    // Read data holds between reads
    always_ff @(posedge clk) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= next_rdata;
        end
    end
endmodule : voltage_comparator_control

// file: analog_source.sv
`timescale 1ns/1ps
module analog_source (
    input wire logic [11:0] pos_mv, // Positive pin level
    input wire logic [11:0] neg_mv, // Negative pin level
    output logic cmp_raw // Comparator result
);
    assign cmp_raw = pos_mv > neg_mv;
endmodule : analog_source

// file: comparator_monitor.sv
`timescale 1ns/1ps
module comparator_monitor
    import comparator_pkg::*;
(
    input wire logic clk, // In
    input wire logic rst, // In
    input wire logic [7:0] sfr_addr, // In
    input wire logic [7:0] sfr_wdata, // In
    input wire logic sfr_wr, // In
    input wire logic cmp_raw, // In
    input wire logic cmp_enable, // In
    input wire logic [1:0] pos_hyst_sel, // In
    input wire logic [1:0] neg_hyst_sel, // In
    input wire logic cmp_sync_out, // In
    input wire logic cmp_async_out, // In
    input wire logic reset_src_en, // In
    input wire logic cmp_reset_req // In
);
    wire wc = sfr_wr && sfr_addr == ctrl_addr;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_steady; (cmp_enable && $stable(cmp_raw)) [*6]; endsequence
    property p_en; wc |=> cmp_enable == $past(sfr_wdata[enable_bit]); endproperty
    a_en: assert property (p_en) else $error("enable not written");
    property p_hys; wc |=> {pos_hyst_sel, neg_hyst_sel} == $past(sfr_wdata[3:0]); endproperty
    a_hys: assert property (p_hys) else $error("hysteresis not written");
    property p_en_hold; !wc |=> $stable(cmp_enable); endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable moved");
    property p_hys_hold; !wc |=> $stable({pos_hyst_sel, neg_hyst_sel}); endproperty
    a_hys_hold: assert property (p_hys_hold) else $error("hysteresis moved");
    property p_rst; $fell(rst) |-> !cmp_enable && {pos_hyst_sel, neg_hyst_sel} == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_dis; !cmp_enable && !$past(cmp_enable) |-> !cmp_sync_out; endproperty
    a_dis: assert property (p_dis) else $error("sync out high while off");
    property p_async; cmp_async_out == (cmp_raw && cmp_enable); endproperty
    a_async: assert property (p_async) else $error("raw out wrong");
    property p_follow; s_steady |-> cmp_sync_out == cmp_raw; endproperty
    a_follow: assert property (p_follow) else $error("sync out stale");
    property p_reset_req; cmp_reset_req |-> $past(cmp_enable) && $past(reset_src_en); endproperty
    a_reset_req: assert property (p_reset_req) else $error("reset request unexpected");
endmodule : comparator_monitor

// file: voltage_comparator_control_tb.sv
`timescale 1ns/1ps
module voltage_comparator_control_tb;
    logic clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, reset_src_en = 0, cmp_raw, cmp_enable;
    logic cmp_sync_out, cmp_async_out, rise_irq, fall_irq, cmp_reset_req;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [11:0] pos_mv = 12'h000, neg_mv = 12'h064;
    logic [1:0] pos_hyst_sel, neg_hyst_sel, response_mode;
    logic [3:0] pos_input_sel, neg_input_sel;
    int errors = 0, n_compared = 0;
    always #50 clk = ~clk;
    voltage_comparator_control voltage_comparator_control_inst (.*);
    analog_source analog_source_inst (.pos_mv(pos_mv), .neg_mv(neg_mv), .cmp_raw(cmp_raw));
    task chk(string n, logic [7:0] s, logic [7:0] e);
        n_compared++;
        errors += (s !== e);
        if (s !== e) $display("mismatch %s exp %h got %h", n, e, s);
    endtask : chk
    task report_and_stop;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task xfer(logic w, logic [7:0] a, logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = w;
        sfr_rd = !w;
        @(negedge clk) {sfr_wr, sfr_rd} = 2'h0;
        @(negedge clk) if (!w) chk("rdata", sfr_rdata, d);
    endtask : xfer
    task t_regs;
        xfer(0, 8'h9b, 8'h00);
        xfer(0, 8'h9f, 8'hff);
        xfer(0, 8'h9d, 8'h02);
        xfer(0, 8'h9c, 8'h00);
        xfer(0, 8'h00, 8'h00);
        chk("input_sel", {neg_input_sel, pos_input_sel}, 8'hff);
        chk("response", {6'h00, response_mode}, 8'h02);
        xfer(1, 8'h9f, 8'h5a);
        chk("input_sel_wr", {neg_input_sel, pos_input_sel}, 8'h5a);
        xfer(1, 8'h9d, 8'h01);
        chk("response_wr", {6'h00, response_mode}, 8'h01);
        xfer(1, 8'h00, 8'hff);
        xfer(0, 8'h9b, 8'h00);
        xfer(1, 8'h9b, 8'hcd);
        chk("enable", {7'h00, cmp_enable}, 8'h01);
        chk("hyst", {4'h0, pos_hyst_sel, neg_hyst_sel}, 8'h0d);
        xfer(0, 8'h9b, 8'h8d);
    endtask : t_regs
    task t_edges;
        xfer(1, 8'h9c, 8'h03);
        xfer(1, 8'h9b, 8'h82);
        pos_mv = 12'h0c8;
        repeat (6) @(negedge clk);
        chk("async", {7'h00, cmp_async_out}, 8'h01);
        chk("sync_out", {7'h00, cmp_sync_out}, 8'h01);
        xfer(0, 8'h9b, 8'he2);
        chk("rise_irq", {7'h00, rise_irq}, 8'h01);
        chk("fall_irq_idle", {7'h00, fall_irq}, 8'h00);
        pos_mv = 12'h000;
        repeat (6) @(negedge clk);
        chk("sync_out_low", {7'h00, cmp_sync_out}, 8'h00);
        xfer(0, 8'h9b, 8'hb2);
        chk("fall_irq", {7'h00, fall_irq}, 8'h01);
        reset_src_en = 1'b1;
        @(negedge clk);
        chk("reset_req", {7'h00, cmp_reset_req}, 8'h01);
        pos_mv = 12'h0c8;
        xfer(1, 8'h9b, 8'h00);
        chk("async_off", {7'h00, cmp_async_out}, 8'h00);
        chk("sync_off", {7'h00, cmp_sync_out}, 8'h00);
        chk("reset_req_off", {7'h00, cmp_reset_req}, 8'h00);
        xfer(0, 8'h9b, 8'h00);
    endtask : t_edges
    initial begin
        repeat (4) @(negedge clk);
        rst = 0;
        t_regs();
        t_edges();
        report_and_stop();
    end
endmodule : voltage_comparator_control_tb
bind voltage_comparator_control comparator_monitor comparator_monitor_inst (.*);
